/* rtl/emac_cfg_pkg.sv */
// constants and carrier types for the mac configuration register block
// assumes a single 125 MHz system clock and a plain register port
package emac_cfg_pkg;

  localparam int NREG = 6;

  // register word index, byte offset is index * 16, alias in address bits 3:2
  localparam logic [2:0] IDX_MAXF = 3'h0;
  localparam logic [2:0] IDX_SUPP = 3'h1;
  localparam logic [2:0] IDX_TEST = 3'h2;
  localparam logic [2:0] IDX_MCFG = 3'h3;
  localparam logic [2:0] IDX_MADR = 3'h4;
  localparam logic [2:0] IDX_MCMD = 3'h5;

  localparam logic [7:0] OFF_MAXF = 8'h00;
  localparam logic [7:0] OFF_SUPP = 8'h10;
  localparam logic [7:0] OFF_TEST = 8'h20;
  localparam logic [7:0] OFF_MCFG = 8'h30;
  localparam logic [7:0] OFF_MADR = 8'h40;
  localparam logic [7:0] OFF_MCMD = 8'h50;

  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLEAR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_INVERT = 2'h3;

  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  // field positions
  localparam int BIT_RMII_RESET = 11;
  localparam int BIT_RMII_SPEED = 8;
  localparam int BIT_TEST_BP = 2;
  localparam int BIT_TEST_PAUSE = 1;
  localparam int BIT_SHORT_QUANTA = 0;
  localparam int BIT_MGMT_RESET = 15;
  localparam int LSB_MGMT_CLOCK_DIVIDER_SELECT = 2;
  localparam int BIT_PREAMBLE_SUPPRESS = 1;
  localparam int BIT_SCAN_INCREMENT = 0;
  localparam int LSB_PHY_ADDR = 8;
  localparam int BIT_SCAN_CMD = 1;

  // index 5 down to 0: mcmd, madr, mcfg, test, supp, maxf
  localparam logic [NREG-1:0][15:0] REG_RESET =
    {16'h0000, 16'h0100, 16'h0020, 16'h0000, 16'h0000, 16'h05ee};
  localparam logic [NREG-1:0][15:0] REG_MASK =
    {16'h0002, 16'h1f00, 16'h803f, 16'h0007, 16'h0900, 16'hffff};

  localparam logic [6:0] QUANTUM_NORMAL = 7'h40;
  localparam logic [6:0] QUANTUM_SHORT = 7'h01;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] SCAN_FIRST_ADDR = 5'h01;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [1:0] size;
  } reg_req_t;

  typedef struct packed {
    logic mgmt_reset;
    logic mdc;
    logic preamble_suppress;
    logic [5:0] preamble_bits;
    logic scan_active;
    logic [4:0] cycle_phy_addr;
  } mgmt_cfg_t;

  typedef struct packed {
    logic rmii_reset;
    logic rmii_speed_100;
    logic test_backpressure;
    logic pause_inhibit;
    logic [6:0] pause_quantum_bytes;
  } mac_ctl_t;

  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    logic [31:0] rdata;
    logic [4:0] div_cnt;
    logic mdc;
    logic [4:0] scan_addr;
    logic oversize;
  } state_t;

  // system clock cycles per management clock period
  function automatic logic [5:0] mdc_divisor(input logic [3:0] sel);
    case (sel)
      4'h0, 4'h1: mdc_divisor = 6'h04;
      4'h2: mdc_divisor = 6'h06;
      4'h3: mdc_divisor = 6'h08;
      4'h4: mdc_divisor = 6'h0a;
      4'h5: mdc_divisor = 6'h0e;
      4'h6: mdc_divisor = 6'h14;
      4'h7: mdc_divisor = 6'h1c;
      default: mdc_divisor = 6'h28;
    endcase
  endfunction

endpackage

/* rtl/ethernet_mac_phy_support_mgmt_cfg.sv */
// mac configuration registers: frame length limit, reduced-mii controls,
// test controls, management config, clock divider and scan addressing
// assumes one clock, synchronous reset, register master per plain strobe port
`timescale 1ns/1ns
`default_nettype none

module ethernet_mac_phy_support_mgmt_cfg (
  input wire logic clk,
  input wire logic rst,
  input wire emac_cfg_pkg::reg_req_t req,
  output logic [31:0] rdata,
  input wire logic rmii_mode,
  input wire logic rx_pause_active,
  input wire logic scan_cycle_done,
  input wire logic rx_frame_done,
  input wire logic [15:0] rx_frame_octets,
  output logic rx_oversize,
  output emac_cfg_pkg::mgmt_cfg_t mgmt,
  output emac_cfg_pkg::mac_ctl_t mac_ctl
);

  emac_cfg_pkg::state_t q;
  emac_cfg_pkg::state_t d;

  logic hit;
  logic size_ok;
  logic [2:0] idx;
  logic [1:0] op;
  logic [15:0] maxf;
  logic [15:0] supp;
  logic [15:0] test;
  logic [15:0] mcfg;
  logic [15:0] madr;
  logic [15:0] mcmd;
  logic [3:0] mgmt_clock_divider_select;
  logic [4:0] half_period;
  logic [4:0] phy_addr;
  logic mgmt_rst;
  logic scan_on;
  logic scan_inc;

  assign idx = req.addr[6:4];
  assign op = req.addr[3:2];
  assign size_ok = (req.size == emac_cfg_pkg::SIZE_16) || (req.size == emac_cfg_pkg::SIZE_32);

  // address decode; anything off the map answers zero and stores nothing
  always_comb
  begin
    if (req.addr[7] || (req.addr[1:0] != 2'h0))
    begin
      hit = 1'b0;
    end
    else if (idx < 3'(emac_cfg_pkg::NREG))
    begin
      hit = 1'b1;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  assign maxf = q.regs[emac_cfg_pkg::IDX_MAXF];
  assign supp = q.regs[emac_cfg_pkg::IDX_SUPP];
  assign test = q.regs[emac_cfg_pkg::IDX_TEST];
  assign mcfg = q.regs[emac_cfg_pkg::IDX_MCFG];
  assign madr = q.regs[emac_cfg_pkg::IDX_MADR];
  assign mcmd = q.regs[emac_cfg_pkg::IDX_MCMD];

  assign mgmt_clock_divider_select = mcfg[emac_cfg_pkg::LSB_MGMT_CLOCK_DIVIDER_SELECT +: 4];
  assign half_period = 5'(emac_cfg_pkg::mdc_divisor(mgmt_clock_divider_select) >> 1);
  assign phy_addr = madr[emac_cfg_pkg::LSB_PHY_ADDR +: 5];
  assign mgmt_rst = mcfg[emac_cfg_pkg::BIT_MGMT_RESET];
  assign scan_on = mcmd[emac_cfg_pkg::BIT_SCAN_CMD];
  assign scan_inc = mcfg[emac_cfg_pkg::BIT_SCAN_INCREMENT];

  always_comb
  begin
    d = q;
    d.rdata = 32'h0000_0000;
    // 8-bit accesses fall through untouched, reads of them answer zero
    if (req.wr && hit && size_ok)
    begin
      case (op)
        emac_cfg_pkg::OP_CLEAR: d.regs[idx] = q.regs[idx] & ~req.wdata[15:0];
        emac_cfg_pkg::OP_SET: d.regs[idx] = q.regs[idx] | req.wdata[15:0];
        emac_cfg_pkg::OP_INVERT: d.regs[idx] = q.regs[idx] ^ req.wdata[15:0];
        default: d.regs[idx] = req.wdata[15:0];
      endcase
      d.regs[idx] = d.regs[idx] & emac_cfg_pkg::REG_MASK[idx];
    end
    if (req.rd && hit && size_ok)
    begin
      d.rdata = {16'h0000, q.regs[idx]};
    end

    // management clock; divider cleared with mdc low and scan pointer back at 1 while in reset
    if (mgmt_rst)
    begin
      d.div_cnt = 5'h00;
      d.mdc = 1'b0;
    end
    else if (q.div_cnt >= half_period - 5'h01)
    begin
      d.div_cnt = 5'h00;
      d.mdc = ~q.mdc;
    end
    else
    begin
      d.div_cnt = q.div_cnt + 5'h01;
    end

    if (mgmt_rst || !scan_on || !scan_inc)
    begin
      d.scan_addr = emac_cfg_pkg::SCAN_FIRST_ADDR;
    end
    else if (scan_cycle_done)
    begin
      if (q.scan_addr >= phy_addr)
      begin
        d.scan_addr = emac_cfg_pkg::SCAN_FIRST_ADDR;
      end
      else
      begin
        d.scan_addr = q.scan_addr + 5'h01;
      end
    end

    d.oversize = rx_frame_done && (rx_frame_octets > maxf);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q.regs <= emac_cfg_pkg::REG_RESET;
      q.rdata <= 32'h0000_0000;
      q.div_cnt <= 5'h00;
      q.mdc <= 1'b0;
      q.scan_addr <= emac_cfg_pkg::SCAN_FIRST_ADDR;
      q.oversize <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign rx_oversize = q.oversize;

  // reduced-mii controls mean nothing to a full mii attachment
  assign mac_ctl.rmii_reset = rmii_mode && supp[emac_cfg_pkg::BIT_RMII_RESET];
  assign mac_ctl.rmii_speed_100 = rmii_mode && supp[emac_cfg_pkg::BIT_RMII_SPEED];
  assign mac_ctl.test_backpressure = test[emac_cfg_pkg::BIT_TEST_BP];
  assign mac_ctl.pause_inhibit = rx_pause_active || test[emac_cfg_pkg::BIT_TEST_PAUSE];
  assign mac_ctl.pause_quantum_bytes = test[emac_cfg_pkg::BIT_SHORT_QUANTA] ?
    emac_cfg_pkg::QUANTUM_SHORT : emac_cfg_pkg::QUANTUM_NORMAL;

  assign mgmt.mgmt_reset = mgmt_rst;
  assign mgmt.mdc = q.mdc;
  assign mgmt.preamble_suppress = mcfg[emac_cfg_pkg::BIT_PREAMBLE_SUPPRESS];
  assign mgmt.preamble_bits = mcfg[emac_cfg_pkg::BIT_PREAMBLE_SUPPRESS] ?
    6'h00 : emac_cfg_pkg::PREAMBLE_BITS;
  assign mgmt.scan_active = scan_on && !mgmt_rst;
  assign mgmt.cycle_phy_addr = (scan_on && scan_inc) ? q.scan_addr : phy_addr;

  a_maxf_readback: assert property (@(posedge clk) disable iff (rst)
    (req.rd && req.addr == emac_cfg_pkg::OFF_MAXF && req.size == emac_cfg_pkg::SIZE_32)
    |=> (rdata == {16'h0000, $past(maxf)}))
    else $error("frame limit read back wrong");

  a_byte_ignored: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.size == emac_cfg_pkg::SIZE_8) |=> (q.regs == $past(q.regs)))
    else $error("8-bit write changed a register");

  a_set_alias: assert property (@(posedge clk) disable iff (rst)
    (req.wr && size_ok && req.addr == (emac_cfg_pkg::OFF_TEST | 8'h08))
    |=> (test == (($past(test) | $past(req.wdata[15:0])) & 16'h0007)))
    else $error("set alias result wrong");

  a_rmii_gate: assert property (@(posedge clk) disable iff (rst)
    !rmii_mode |-> (!mac_ctl.rmii_reset && !mac_ctl.rmii_speed_100))
    else $error("reduced-mii control leaked");

  a_pause_quanta: assert property (@(posedge clk) disable iff (rst)
    mac_ctl.pause_quantum_bytes == (test[0] ? 7'h01 : 7'h40))
    else $error("pause quantum wrong");

  a_mdc_by_eight: assert property (@(posedge clk) disable iff (rst)
    ($rose(q.mdc) && mgmt_clock_divider_select == 4'h3 && !mgmt_rst) ##1 (mgmt_clock_divider_select == 4'h3 && !mgmt_rst) [*4]
    |-> (!q.mdc && $past(q.mdc) && $past(q.mdc, 2) && $past(q.mdc, 3)))
    else $error("management clock half period wrong");

  a_mgmt_hold: assert property (@(posedge clk) disable iff (rst)
    mgmt_rst |=> (!q.mdc && q.div_cnt == 5'h00))
    else $error("management clock ran in reset");

  a_scan_wrap: assert property (@(posedge clk) disable iff (rst)
    (scan_cycle_done && scan_on && scan_inc && !mgmt_rst && q.scan_addr >= phy_addr &&
    !req.wr) |=> (q.scan_addr == 5'h01))
    else $error("scan address did not wrap to 1");

  a_oversize_flag: assert property (@(posedge clk) disable iff (rst)
    (rx_frame_done && rx_frame_octets > maxf && !req.wr) |=> rx_oversize)
    else $error("oversized frame not flagged");

  a_test_pause: assert property (@(posedge clk) disable iff (rst)
    test[emac_cfg_pkg::BIT_TEST_PAUSE] |-> mac_ctl.pause_inhibit)
    else $error("test pause did not inhibit");

  a_rmii_follow: assert property (@(posedge clk) disable iff (rst)
    rmii_mode |-> (mac_ctl.rmii_reset == supp[11] && mac_ctl.rmii_speed_100 == supp[8]))
    else $error("reduced-mii control not following its bits");

  a_backpressure_bit: assert property (@(posedge clk) disable iff (rst)
    mac_ctl.test_backpressure == test[2])
    else $error("backpressure control wrong");

  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !req.rd |=> (rdata == 32'h0000_0000))
    else $error("read data left standing");

  a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
    (req.rd && (req.addr[7] || req.addr[6:4] > 3'h5)) |=> (rdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  a_refused_read: assert property (@(posedge clk) disable iff (rst)
    (req.rd && !size_ok) |=> (rdata == 32'h0000_0000))
    else $error("refused read not zero");

  a_odd_size_ignored: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.size == 2'h3) |=> (q.regs == $past(q.regs)))
    else $error("size 3 write changed a register");

  a_plain_write: assert property (@(posedge clk) disable iff (rst)
    (req.wr && size_ok && req.addr == emac_cfg_pkg::OFF_MAXF)
    |=> (maxf == $past(req.wdata[15:0])))
    else $error("frame limit write lost");

  a_clear_alias: assert property (@(posedge clk) disable iff (rst)
    (req.wr && size_ok && req.addr == (emac_cfg_pkg::OFF_SUPP | 8'h04))
    |=> (supp == ($past(supp) & ~$past(req.wdata[15:0]))))
    else $error("clear alias result wrong");

  a_invert_alias: assert property (@(posedge clk) disable iff (rst)
    (req.wr && size_ok && req.addr == (emac_cfg_pkg::OFF_MCFG | 8'h0c))
    |=> (mcfg == (($past(mcfg) ^ $past(req.wdata[15:0])) & 16'h803f)))
    else $error("invert alias result wrong");

  a_preamble_map: assert property (@(posedge clk) disable iff (rst)
    (mgmt.preamble_suppress == mcfg[1]) &&
    (mgmt.preamble_bits == (mcfg[1] ? 6'h00 : 6'h20)))
    else $error("preamble setting wrong");

  a_div_range: assert property (@(posedge clk) disable iff (rst)
    q.div_cnt < 5'h14)
    else $error("clock divider counter out of range");

  a_scan_gate: assert property (@(posedge clk) disable iff (rst)
    mgmt.scan_active == (mcmd[1] && !mcfg[15]))
    else $error("scan request not gated by management reset");

  a_scan_step: assert property (@(posedge clk) disable iff (rst)
    (scan_cycle_done && scan_on && scan_inc && !mgmt_rst && q.scan_addr < phy_addr)
    |=> (q.scan_addr == $past(q.scan_addr) + 5'h01))
    else $error("scan address did not step");

  a_scan_fixed: assert property (@(posedge clk) disable iff (rst)
    !(scan_on && scan_inc) |-> (mgmt.cycle_phy_addr == phy_addr))
    else $error("cycle address not the programmed phy");

  a_oversize_quiet: assert property (@(posedge clk) disable iff (rst)
    !(rx_frame_done && rx_frame_octets > maxf) |=> !rx_oversize)
    else $error("oversize flag without cause");

endmodule // ethernet_mac_phy_support_mgmt_cfg

`default_nettype wire

/* bench/phy_mgmt_model.sv */
// far-side phy model: answers scan reads with a done pulse per read
// assumes the management config outputs of the register block
`timescale 1ns/1ns
`default_nettype none

module phy_mgmt_model (
  input wire logic clk,
  input wire logic rst,
  input wire emac_cfg_pkg::mgmt_cfg_t mgmt,
  input wire logic slow,
  output logic scan_cycle_done
);
  logic [4:0] cnt_q;
  logic [4:0] gap;
  assign gap = slow ? 5'h10 : 5'h02;
  // one read finishes every gap + 1 cycles while scanning runs
  always_ff @(posedge clk)
  begin
    if (rst || !mgmt.scan_active)
    begin
      cnt_q <= 5'h00;
      scan_cycle_done <= 1'b0;
    end
    else
    begin
      scan_cycle_done <= (cnt_q == gap);
      cnt_q <= (cnt_q == gap) ? 5'h00 : cnt_q + 5'h01;
    end
  end
endmodule // phy_mgmt_model
`default_nettype wire

/* bench/tb_ethernet_mac_phy_support_mgmt_cfg.sv */
// self-checking bench of the mac configuration register block
// assumes the phy model drives scan completions
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

module tb_ethernet_mac_phy_support_mgmt_cfg;
  logic clk = 1'b0;
  logic rst = 1'b1;
  emac_cfg_pkg::reg_req_t req;
  logic [31:0] rdata;
  logic rmii_mode, rx_pause_active, scan_cycle_done, rx_frame_done, rx_oversize, slow;
  logic [15:0] rx_frame_octets;
  emac_cfg_pkg::mgmt_cfg_t mgmt;
  emac_cfg_pkg::mac_ctl_t mac_ctl;
  int failures = 0;
  int n_compared = 0;
  int n;
  logic [31:0] seed = 32'h00007f2c;
  logic [31:0] r;
  logic [15:0] m [6];
  logic [15:0] lim, o;
  int dv [10] = '{4, 4, 6, 8, 10, 14, 20, 28, 40, 40};

  always #4 clk = ~clk;

  ethernet_mac_phy_support_mgmt_cfg i_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .rmii_mode(rmii_mode), .rx_pause_active(rx_pause_active),
    .scan_cycle_done(scan_cycle_done), .rx_frame_done(rx_frame_done),
    .rx_frame_octets(rx_frame_octets), .rx_oversize(rx_oversize), .mgmt(mgmt),
    .mac_ctl(mac_ctl));
  phy_mgmt_model i_phy (.clk(clk), .rst(rst), .mgmt(mgmt), .slow(slow),
    .scan_cycle_done(scan_cycle_done));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] nxt(logic [15:0] v, logic [1:0] op, logic [15:0] d,
    logic [15:0] k);
    case (op)
      emac_cfg_pkg::OP_CLEAR: return v & ~d;
      emac_cfg_pkg::OP_SET: return (v | d) & k;
      emac_cfg_pkg::OP_INVERT: return (v ^ d) & k;
      default: return d & k;
    endcase
  endfunction

  function automatic emac_cfg_pkg::mac_ctl_t ctl_exp();
    emac_cfg_pkg::mac_ctl_t c;
    c.rmii_reset = rmii_mode & m[1][11];
    c.rmii_speed_100 = rmii_mode & m[1][8];
    c.test_backpressure = m[2][2];
    c.pause_inhibit = rx_pause_active | m[2][1];
    c.pause_quantum_bytes = m[2][0] ? 7'h01 : 7'h40;
    return c;
  endfunction

  task automatic final_report();
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // model follows only accesses the block accepts
  task automatic wrx(logic [2:0] i, logic [1:0] op, logic [31:0] d, logic [1:0] s);
    @(posedge clk);
    req.addr <= {1'b0, i, op, 2'b00};
    req.wdata <= d;
    req.size <= s;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    if (i < 3'h6 && (s == emac_cfg_pkg::SIZE_16 || s == emac_cfg_pkg::SIZE_32))
      m[i] = nxt(m[i], op, d[15:0], emac_cfg_pkg::REG_MASK[i]);
  endtask

  task automatic rd(logic [7:0] a, logic [1:0] s = emac_cfg_pkg::SIZE_32);
    logic [31:0] e;
    e = (a[6:4] < 3'h6 && !a[7] && (s == emac_cfg_pkg::SIZE_16 || s == emac_cfg_pkg::SIZE_32))
      ? {16'h0000, m[a[6:4]]} : 32'h0000_0000;
    @(posedge clk);
    req.addr <= a;
    req.size <= s;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic rise();
    logic last;
    n = 0;
    do
    begin
      last = mgmt.mdc;
      @(posedge clk);
      #1;
      n++;
    end while (!(last === 1'b0 && mgmt.mdc === 1'b1) && n < 200);
    if (n >= 200)
    begin
      failures++;
      final_report();
    end
  endtask

  task automatic wchg(logic [4:0] e);
    logic [4:0] old;
    int k;
    old = mgmt.cycle_phy_addr;
    k = 0;
    r = rnd();
    slow <= r[0];
    while (mgmt.cycle_phy_addr === old && k < 100)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 100)
    begin
      failures++;
      final_report();
    end
    `CHK(mgmt.cycle_phy_addr, e)
  endtask

  initial
  begin
    req <= '0;
    {rmii_mode, rx_pause_active, rx_frame_done, slow} <= 4'h0;
    rx_frame_octets <= 16'h0000;
    for (int i = 0; i < 6; i++) m[i] = emac_cfg_pkg::REG_RESET[i];
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd({1'b0, i[2:0], 4'h0});
    rd(8'h80);
    for (int t = 0; t < 80; t++)
    begin
      r = rnd();
      @(posedge clk);
      rmii_mode <= r[20];
      rx_pause_active <= r[21];
      wrx(r[2:0], r[4:3], rnd(), r[6:5]);
      rd({1'b0, r[2:0], r[8:7], 2'b00}, r[10:9]);
      `CHK(mac_ctl, ctl_exp())
      `CHK(mgmt.preamble_bits, m[3][1] ? 6'h00 : 6'h20)
      `CHK(mgmt.preamble_suppress, m[3][1])
      `CHK(mgmt.mgmt_reset, m[3][15])
      `CHK(mgmt.scan_active, m[5][1] & ~m[3][15])
    end
    // test controls back to normal before the functional scenarios
    wrx(3'h2, emac_cfg_pkg::OP_WRITE, 32'h0000_0000, emac_cfg_pkg::SIZE_32);
    #1;
    `CHK(mac_ctl.pause_quantum_bytes, 7'h40)
    for (int c = 0; c < 10; c++)
    begin
      wrx(3'h3, emac_cfg_pkg::OP_WRITE, c << 2, emac_cfg_pkg::SIZE_32);
      rise();
      rise();
      `CHK(n, dv[c])
    end
    wrx(3'h4, emac_cfg_pkg::OP_WRITE, 32'h0300, emac_cfg_pkg::SIZE_16);
    wrx(3'h5, emac_cfg_pkg::OP_WRITE, 32'h0000, emac_cfg_pkg::SIZE_16);
    wrx(3'h3, emac_cfg_pkg::OP_WRITE, 32'h0021, emac_cfg_pkg::SIZE_16);
    wrx(3'h5, emac_cfg_pkg::OP_WRITE, 32'h0002, emac_cfg_pkg::SIZE_16);
    #1;
    `CHK(mgmt.cycle_phy_addr, 5'h01)
    for (int k = 0; k < 5; k++) wchg(5'((k + 1) % 3 + 1));
    wrx(3'h3, emac_cfg_pkg::OP_SET, 32'h8000, emac_cfg_pkg::SIZE_32);
    n = 0;
    repeat (60)
    begin
      @(posedge clk);
      #1;
      if (mgmt.mdc !== 1'b0 || mgmt.scan_active !== 1'b0) n++;
    end
    `CHK(n, 0)
    for (int k = 0; k < 12; k++)
    begin
      r = rnd();
      lim = (k < 2) ? 16'h05f7 : {r[15:1], 1'b0};
      wrx(3'h0, emac_cfg_pkg::OP_WRITE, {16'h0000, lim}, emac_cfg_pkg::SIZE_32);
      o = (k % 3 == 0) ? lim : (k % 3 == 1) ? lim + 16'h0001 : r[31:16];
      @(posedge clk);
      rx_frame_done <= 1'b1;
      rx_frame_octets <= o;
      @(posedge clk);
      rx_frame_done <= 1'b0;
      #1;
      `CHK(rx_oversize, o > lim)
      @(posedge clk);
      #1;
      `CHK(rx_oversize, 1'b0)
    end
    // second reset in mid-run must bring every register back
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) m[i] = emac_cfg_pkg::REG_RESET[i];
    for (int i = 0; i < 6; i++) rd({1'b0, i[2:0], 4'h0}, emac_cfg_pkg::SIZE_16);
    final_report();
  end
endmodule // tb_ethernet_mac_phy_support_mgmt_cfg
`default_nettype wire
